//--- dv/ufc_flow_ctrl_monitor.sv
/*
  Port checker for the flow-control block: APB answer, receive push,
  flow character hand-over and flow pin selection.
  Assumes one clock domain and binding onto ufc_flow_ctrl.
*/
`timescale 1ns/1ps
`default_nettype none
module ufc_flow_ctrl_monitor (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       rx_char_valid,
  input wire logic [7:0] rx_char,
  input wire logic       rx_fifo_push,
  input wire logic [7:0] rx_fifo_data,
  input wire logic       flow_char_req,
  input wire logic [7:0] flow_char_data,
  input wire logic       flow_char_ack,
  input wire logic       flow_request_out,
  input wire logic       terminal_ready_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // the two apb phases
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  // zero wait states: the access cycle must answer at once
  acc_ready_a: assert property (s_setup ##1 s_access |-> pready)
    else $error("no pready in access phase");
  idle_ready_a: assert property (!penable |-> !pready)
    else $error("pready outside access phase");
  err_scope_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  push_cause_a: assert property (rx_fifo_push |-> $past(rx_char_valid))
    else $error("push without a received char");
  push_data_a: assert property (
    rx_fifo_push |-> rx_fifo_data == $past(rx_char))
    else $error("pushed data differs from received char");
  req_stands_a: assert property (
    flow_char_req && !flow_char_ack |=> flow_char_req)
    else $error("flow char request dropped before ack");
  req_data_a: assert property (
    flow_char_req && !flow_char_ack |=> $stable(flow_char_data))
    else $error("flow char changed before ack");
  pin_one_a: assert property (!(flow_request_out && terminal_ready_out))
    else $error("both flow pins active");
endmodule
bind ufc_flow_ctrl ufc_flow_ctrl_monitor mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .rx_char_valid(rx_char_valid),
  .rx_char(rx_char), .rx_fifo_push(rx_fifo_push),
  .rx_fifo_data(rx_fifo_data), .flow_char_req(flow_char_req),
  .flow_char_data(flow_char_data), .flow_char_ack(flow_char_ack),
  .flow_request_out(flow_request_out),
  .terminal_ready_out(terminal_ready_out));
`default_nettype wire

//--- dv/ufc_flow_ctrl_tb_top.sv
/*
  Self-checking bench for the flow-control block: APB master, receive
  stream, fifo count and baud ticks; queues hold expected results.
  Assumes zero-wait APB and the remote model acknowledging flow chars.
*/
`timescale 1ns/1ps
`default_nettype none
module ufc_flow_ctrl_tb_top;
  import ufc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, rx_char_valid;
  logic        rhr_read, baud_tick, flow_char_ack, slow, took;
  logic        pready, pslverr, rx_fifo_push, tx_hold, flow_char_req;
  logic        flow_request_out, terminal_ready_out, irq_out;
  logic        thr_empty, thr_write, flow_permit_in, set_ready_in;
  logic [7:0]  paddr, rx_char, rx_fifo_count, rnd, took_char;
  logic [7:0]  rx_fifo_data, flow_char_data;
  logic [1:0]  tc;
  logic [31:0] pwdata, prdata;
  logic [32:0] exp_rd[$];
  logic [7:0]  exp_push[$], exp_flow[$];
  int          failures, comparisons;
  ufc_flow_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .prdata, .rx_char_valid, .rx_char,
    .rx_fifo_count, .rhr_read, .baud_tick, .thr_empty,
    .thr_write, .flow_char_ack, .flow_permit_in,
    .set_ready_in, .rx_fifo_push, .rx_fifo_data, .tx_hold,
    .flow_char_req, .flow_char_data, .flow_request_out,
    .terminal_ready_out, .irq_out);
  ufc_remote_model partner (.pclk, .presetn, .slow, .flow_char_req,
    .flow_char_data, .flow_char_ack, .took, .took_char);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // one receive bit period every four clocks
  always @(posedge pclk) begin
    tc <= tc + 2'h1;
    baud_tick <= (tc == 2'h3);
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: pin %b, wanted %b", $time, got, exp);
    end
  endtask
  // results are matched against the oldest note as they appear
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite)
      chk({pslverr, prdata}, exp_rd.size() ? exp_rd.pop_front() : 'x);
    if (rx_fifo_push)
      chk({25'h0, rx_fifo_data}, exp_push.size() ? exp_push.pop_front() : 'x);
    if (took)
      chk({25'h0, took_char}, exp_flow.size() ? exp_flow.pop_front() : 'x);
  end
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [7:0] d, input logic [32:0] e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    if (!w) exp_rd.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (!pready && n < 50);
    if (n >= 50) chk1(1'b0, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, '0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00, {25'h0, e});
  endtask
  task automatic rx(input logic [7:0] c, input logic pushed);
    rx_char_valid <= 1'b1;
    rx_char <= c;
    if (pushed) exp_push.push_back(c);
    @(posedge pclk);
    rx_char_valid <= 1'b0;
    tick(3);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    tick(5000);
    failures++;
    $display("unexpected at %0t: watchdog ran out", $time);
    print_verdict;
  end
  initial begin
    {presetn, psel, penable, pwrite, rx_char_valid, rhr_read, slow} = '0;
    {paddr, rx_char, rx_fifo_count, pwdata, tc, baud_tick} = '0;
    {failures, comparisons} = '0;
    {thr_write, flow_permit_in, set_ready_in} = '0;
    thr_empty = 1'b1;
    rnd = 8'h30;
    tick(2);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) rd(UFC_ADDR_XON1 + 8'(4 * i), 8'h00);
    apb(1'b0, 8'h3C, 8'h00, {1'b1, 32'h0});
    wr(UFC_ADDR_IER, 8'h02);
    // irq_out is a flop: look one edge after the enable has landed
    tick(1);
    chk1(irq_out, 1'b1);
    rd(UFC_ADDR_ISR, UFC_ISR_THR);
    // a fresh empty edge after a holding write raises the source again
    thr_empty <= 1'b0;
    thr_write <= 1'b1;
    @(posedge pclk);
    thr_write <= 1'b0;
    thr_empty <= 1'b1;
    tick(2);
    rd(UFC_ADDR_ISR, UFC_ISR_THR);
    wr(UFC_ADDR_IER, 8'h21);
    wr(UFC_ADDR_XON1, 8'h11);
    wr(UFC_ADDR_XOFF1, 8'h13);
    rd(UFC_ADDR_XOFF1, 8'h13);
    wr(UFC_ADDR_LCR, 8'h03);
    wr(UFC_ADDR_FLWH, 8'h0A);
    wr(UFC_ADDR_FLWL, 8'h04);
    wr(UFC_ADDR_EFR, 8'h4A);
    slow <= 1'b1;
    exp_flow.push_back(8'h13);
    rx_fifo_count <= 8'h09;
    tick(3);
    chk1(flow_request_out, 1'b0);
    rx_fifo_count <= 8'h0A;
    tick(3);
    chk1(flow_request_out, 1'b1);
    rx_fifo_count <= 8'h05;
    tick(3);
    chk1(flow_request_out, 1'b1);
    slow <= 1'b0;
    exp_flow.push_back(8'h11);
    rx_fifo_count <= 8'h04;
    tick(12);
    chk1(flow_request_out, 1'b0);
    rx_fifo_count <= 8'h00;
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      rx({1'b1, rnd[6:0]}, 1'b1);
    end
    rx(8'h13, 1'b0);
    chk1(tx_hold, 1'b1);
    rd(UFC_ADDR_ISR, UFC_ISR_XOFF);
    rx(8'h11, 1'b0);
    chk1(tx_hold, 1'b0);
    rd(UFC_ADDR_ISR, UFC_ISR_NONE);
    wr(UFC_ADDR_LCR, 8'h00);
    rx(8'hF3, 1'b0);
    chk1(tx_hold, 1'b1);
    rx(8'hF1, 1'b0);
    chk1(tx_hold, 1'b0);
    wr(UFC_ADDR_LCR, 8'h03);
    // special detect with software flow off: char kept, bit 4 set
    wr(UFC_ADDR_EFR, 8'h20);
    wr(UFC_ADDR_XOFF2, 8'h5A);
    rx(8'h5A, 1'b1);
    rd(UFC_ADDR_ISR, UFC_ISR_XOFF);
    wr(UFC_ADDR_EFR, 8'h4A);
    wr(UFC_ADDR_AFC1, 8'h04);
    exp_flow.push_back(8'h13);
    rx_fifo_count <= 8'h0C;
    tick(6);
    chk1(terminal_ready_out, 1'b1);
    chk1(flow_request_out, 1'b0);
    exp_flow.push_back(8'h11);
    rx_fifo_count <= 8'h02;
    tick(6);
    chk1(terminal_ready_out, 1'b0);
    // permit watching: remapped, only the set-ready pin may halt
    wr(UFC_ADDR_EFR, 8'hCA);
    flow_permit_in <= 1'b1;
    tick(2);
    chk1(tx_hold, 1'b0);
    set_ready_in <= 1'b1;
    tick(2);
    chk1(tx_hold, 1'b1);
    set_ready_in <= 1'b0;
    wr(UFC_ADDR_AFC1, 8'h00);
    chk1(tx_hold, 1'b1);
    flow_permit_in <= 1'b0;
    // restart the timeout, look just short of and just past forty ticks
    rhr_read <= 1'b1;
    @(posedge pclk);
    rhr_read <= 1'b0;
    tick(140);
    rd(UFC_ADDR_ISR, UFC_ISR_RX);
    chk1(irq_out, 1'b1);
    tick(30);
    rd(UFC_ADDR_ISR, UFC_ISR_TOUT);
    // second reset mid-run: flow chars cleared, empty source pending
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(UFC_ADDR_XOFF1, 8'h00);
    wr(UFC_ADDR_IER, 8'h02);
    rd(UFC_ADDR_ISR, UFC_ISR_THR);
    // level registers zero again: fifo control 7:6 = 01 gives 16 and 7
    wr(UFC_ADDR_FCR, 8'h40);
    wr(UFC_ADDR_EFR, 8'h40);
    rx_fifo_count <= 8'h0F;
    tick(3);
    chk1(flow_request_out, 1'b0);
    rx_fifo_count <= 8'h10;
    tick(3);
    chk1(flow_request_out, 1'b1);
    rx_fifo_count <= 8'h07;
    tick(3);
    chk1(flow_request_out, 1'b0);
    chk(33'(exp_rd.size() + exp_push.size() + exp_flow.size()), '0);
    print_verdict;
  end
endmodule
`default_nettype wire

//--- dv/ufc_remote_model.sv
/*
  Transmitter side model: takes offered flow characters, promptly or slowly.
  Assumes the request is held until acknowledged.
*/
`timescale 1ns/1ps
`default_nettype none
module ufc_remote_model (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       slow,
  input wire logic       flow_char_req,
  input wire logic [7:0] flow_char_data,
  output logic           flow_char_ack,
  output logic           took,
  output logic [7:0]     took_char
);
  logic [2:0] wait_r;
  logic       gap_r;
  // one-cycle ack, then a gap so a held request is never taken twice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flow_char_ack <= 1'b0;
      took <= 1'b0;
      took_char <= 8'h00;
      wait_r <= 3'h0;
      gap_r <= 1'b0;
    end else begin
      flow_char_ack <= 1'b0;
      took <= 1'b0;
      gap_r <= 1'b0;
      if (!gap_r && flow_char_req) begin
        if (wait_r >= (slow ? 3'h4 : 3'h0)) begin
          flow_char_ack <= 1'b1;
          took <= 1'b1;
          took_char <= flow_char_data;
          wait_r <= 3'h0;
          gap_r <= 1'b1;
        end else begin
          wait_r <= wait_r + 3'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/ufc_flow_ctrl.sv
/*
  Flow-control, flow-character detect and receive-interrupt logic of one
  UART channel, with an APB register slave.
  Assumes the receiver strobes each character at its stop-bit centre, the
  transmitter honours tx_hold only between characters and sends the flow
  character offered on flow_char_req, and a bit-period tick from the
  receive baud clock. All inputs are synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module ufc_flow_ctrl
  import ufc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        rx_char_valid,
  input  wire logic [7:0]  rx_char,
  input  wire logic [7:0]  rx_fifo_count,
  input  wire logic        rhr_read,
  input  wire logic        baud_tick,
  input  wire logic        thr_empty,
  input  wire logic        thr_write,
  input  wire logic        flow_char_ack,
  input  wire logic        flow_permit_in,
  input  wire logic        set_ready_in,
  output logic             rx_fifo_push,
  output logic [7:0]       rx_fifo_data,
  output logic             tx_hold,
  output logic             flow_char_req,
  output logic [7:0]       flow_char_data,
  output logic             flow_request_out,
  output logic             terminal_ready_out,
  output logic             irq_out
);

  ufc_state_t s_r;
  ufc_state_t s_nxt;

  logic       ext_mode;
  logic [7:0] hi_lvl;
  logic [7:0] lo_lvl;
  logic [7:0] rx_lvl;
  logic       rx_trig;
  logic [7:0] wmask;
  logic       on1;
  logic       on2;
  logic       off1;
  logic       off2;
  logic       dbl;
  logic       xoff_hit;
  logic       xon_hit;
  logic       flow_chr;
  logic       special;
  logic       permit_sel;
  logic       cts_halt;
  logic [7:0] tout_lim;
  logic [7:0] interrupt_status_reg;
  logic       acc;
  logic       setup;
  logic       addr_ok;
  logic       isr_rd;

  function automatic logic chr_eq(input logic [7:0] a, input logic [7:0] b,
                                  input logic [7:0] m);
    chr_eq = ((a ^ b) & m) == 8'h00;
  endfunction

  // threshold selection: extended levels once any level register is set
  always_comb begin
    ext_mode = (s_r.txlvl | s_r.rxlvl | s_r.flwh | s_r.flwl) != 8'h00;
    if (ext_mode) begin
      hi_lvl = s_r.flwh;
      lo_lvl = s_r.flwl;
      rx_lvl = s_r.rxlvl;
    end else begin
      hi_lvl = UFC_LEG_HI[s_r.fifo_control_reg[7:6]];
      lo_lvl = UFC_LEG_LO[s_r.fifo_control_reg[7:6]];
      rx_lvl = UFC_LEG_RX[s_r.fifo_control_reg[7:6]];
    end
  end

  // a zero rx level would fire on an empty fifo, so it acts as one
  assign rx_trig = (rx_fifo_count != 8'h00) &&
                   (rx_fifo_count >= rx_lvl);

  // received character compare, limited to the active word length
  always_comb begin
    wmask    = 8'hFF >> (2'd3 - s_r.line_control_reg[1:0]);
    on1      = chr_eq(rx_char, s_r.xon1, wmask);
    on2      = chr_eq(rx_char, s_r.xon2, wmask);
    off1     = chr_eq(rx_char, s_r.xoff1, wmask);
    off2     = chr_eq(rx_char, s_r.xoff2, wmask);
    dbl      = s_r.enhanced_feature_reg[UFC_EFR_RXDBL];
    xoff_hit = rx_char_valid && s_r.enhanced_feature_reg[UFC_EFR_RXSW] &&
               (dbl ? (s_r.prev_off && off2) : off1);
    xon_hit  = rx_char_valid && s_r.enhanced_feature_reg[UFC_EFR_RXSW] &&
               (dbl ? (s_r.prev_on && on2) : on1);
    // in double mode a first-of-pair match is also withheld
    flow_chr = s_r.enhanced_feature_reg[UFC_EFR_RXSW] &&
               (xoff_hit || xon_hit || off1 || on1);
    special  = rx_char_valid && s_r.enhanced_feature_reg[UFC_EFR_SPEC] && off2;
  end

  // permit input, optionally taken from the set-ready pin
  assign permit_sel = s_r.afc1[UFC_AFC1_REMAP] ? set_ready_in
                                               : flow_permit_in;
  assign cts_halt   = s_r.enhanced_feature_reg[UFC_EFR_AUTOC] && permit_sel;

  // timeout limit: four characters of start, data, parity and stop bits
  always_comb begin
    tout_lim = 8'(UFC_START_BITS + UFC_MIN_WORD + {2'b00, s_r.line_control_reg[1:0]} +
               {3'b000, s_r.line_control_reg[UFC_LCR_PAR]} +
               (s_r.line_control_reg[UFC_LCR_STOP] ? 4'h2 : 4'h1));
    tout_lim = 8'(tout_lim * UFC_TOUT_CHARS);
  end

  // one pending source shown, highest priority first
  always_comb begin
    if (s_r.interrupt_enable_reg[UFC_IER_RX] && s_r.tout)
      interrupt_status_reg = UFC_ISR_TOUT;
    else if (s_r.interrupt_enable_reg[UFC_IER_RX] && rx_trig)
      interrupt_status_reg = UFC_ISR_RX;
    else if (s_r.interrupt_enable_reg[UFC_IER_THR] && s_r.thri)
      interrupt_status_reg = UFC_ISR_THR;
    else if (s_r.interrupt_enable_reg[UFC_IER_RX] && s_r.sflag)
      interrupt_status_reg = UFC_ISR_XOFF;
    else if (s_r.interrupt_enable_reg[UFC_IER_CTS] && s_r.ctsf)
      interrupt_status_reg = UFC_ISR_CTS;
    else
      interrupt_status_reg = UFC_ISR_NONE;
  end

  // apb decode; zero wait states, unmapped addresses answer with an error
  always_comb begin
    setup   = psel && !penable;
    acc     = psel && penable;
    addr_ok = (paddr[1:0] == 2'b00) && (paddr <= UFC_ADDR_STAT);
    isr_rd  = acc && !pwrite && (paddr == UFC_ADDR_ISR);
  end

  assign pready  = acc;
  assign pslverr = acc && !addr_ok;

  // next state of everything the block holds
  always_comb begin
    s_nxt = s_r;

    // read data is captured in the setup cycle, so prdata is a flop
    if (setup && !pwrite) begin
      case (paddr)
        UFC_ADDR_IER:   s_nxt.prdata = {24'h00_0000, s_r.interrupt_enable_reg};
        UFC_ADDR_FCR:   s_nxt.prdata = {24'h00_0000, s_r.fifo_control_reg};
        UFC_ADDR_LCR:   s_nxt.prdata = {24'h00_0000, s_r.line_control_reg};
        UFC_ADDR_EFR:   s_nxt.prdata = {24'h00_0000, s_r.enhanced_feature_reg};
        UFC_ADDR_XON1:  s_nxt.prdata = {24'h00_0000, s_r.xon1};
        UFC_ADDR_XON2:  s_nxt.prdata = {24'h00_0000, s_r.xon2};
        UFC_ADDR_XOFF1: s_nxt.prdata = {24'h00_0000, s_r.xoff1};
        UFC_ADDR_XOFF2: s_nxt.prdata = {24'h00_0000, s_r.xoff2};
        UFC_ADDR_TXLVL: s_nxt.prdata = {24'h00_0000, s_r.txlvl};
        UFC_ADDR_RXLVL: s_nxt.prdata = {24'h00_0000, s_r.rxlvl};
        UFC_ADDR_FLWH:  s_nxt.prdata = {24'h00_0000, s_r.flwh};
        UFC_ADDR_FLWL:  s_nxt.prdata = {24'h00_0000, s_r.flwl};
        UFC_ADDR_AFC1:  s_nxt.prdata = {24'h00_0000, s_r.afc1};
        UFC_ADDR_ISR:   s_nxt.prdata = {24'h00_0000, interrupt_status_reg};
        UFC_ADDR_STAT:  s_nxt.prdata = {26'h000_0000, s_r.tout, cts_halt,
                                        s_r.xoff_sent, s_r.sw_halt,
                                        s_r.rts_off, ext_mode};
        default:        s_nxt.prdata = 32'h0000_0000;
      endcase
    end

    // register writes take effect at the access edge
    if (acc && pwrite) begin
      case (paddr)
        UFC_ADDR_IER:   s_nxt.interrupt_enable_reg   = pwdata[7:0];
        UFC_ADDR_FCR:   s_nxt.fifo_control_reg   = pwdata[7:0];
        UFC_ADDR_LCR:   s_nxt.line_control_reg   = pwdata[7:0];
        UFC_ADDR_EFR:   s_nxt.enhanced_feature_reg   = pwdata[7:0];
        UFC_ADDR_XON1:  s_nxt.xon1  = pwdata[7:0];
        UFC_ADDR_XON2:  s_nxt.xon2  = pwdata[7:0];
        UFC_ADDR_XOFF1: s_nxt.xoff1 = pwdata[7:0];
        UFC_ADDR_XOFF2: s_nxt.xoff2 = pwdata[7:0];
        UFC_ADDR_TXLVL: s_nxt.txlvl = pwdata[7:0];
        UFC_ADDR_RXLVL: s_nxt.rxlvl = pwdata[7:0];
        UFC_ADDR_FLWH:  s_nxt.flwh  = pwdata[7:0];
        UFC_ADDR_FLWL:  s_nxt.flwl  = pwdata[7:0];
        UFC_ADDR_AFC1:  s_nxt.afc1  = pwdata[7:0];
        default:        s_nxt.afc1  = s_r.afc1;
      endcase
    end

    // hardware flow output: off at the high level, back on at the low level
    if (!s_r.enhanced_feature_reg[UFC_EFR_AUTOR])
      s_nxt.rts_off = 1'b0;
    else if (rx_fifo_count >= hi_lvl)
      s_nxt.rts_off = 1'b1;
    else if (rx_fifo_count <= lo_lvl)
      s_nxt.rts_off = 1'b0;

    // receive side flow characters; stopping takes effect between chars
    if (xoff_hit)
      s_nxt.sw_halt = 1'b1;
    else if (xon_hit)
      s_nxt.sw_halt = 1'b0;
    if (rx_char_valid) begin
      s_nxt.prev_off = dbl && off1;
      s_nxt.prev_on  = dbl && on1;
    end

    // status bit 4: service clears, while a new match in the same cycle wins
    if (xon_hit || (isr_rd && interrupt_status_reg == UFC_ISR_XOFF))
      s_nxt.sflag = 1'b0;
    if ((xoff_hit && s_r.interrupt_enable_reg[UFC_IER_XOFF]) || special)
      s_nxt.sflag = 1'b1;

    // flow characters are swallowed, special characters are kept
    s_nxt.push      = rx_char_valid && (!flow_chr || special);
    s_nxt.push_data = rx_char;

    // transmit side flow characters, one or two per event
    if (s_r.snd_pend) begin
      if (flow_char_ack) begin
        if (s_r.enhanced_feature_reg[UFC_EFR_TXDBL] && !s_r.snd_idx) begin
          s_nxt.snd_idx  = 1'b1;
          s_nxt.snd_data = s_r.xoff_sent ? s_r.xoff2 : s_r.xon2;
        end else begin
          s_nxt.snd_pend = 1'b0;
          s_nxt.snd_idx  = 1'b0;
        end
      end
    end else if (!s_r.enhanced_feature_reg[UFC_EFR_TXSW]) begin
      s_nxt.xoff_sent = 1'b0;
    end else if (!s_r.xoff_sent && rx_fifo_count >= hi_lvl) begin
      s_nxt.xoff_sent = 1'b1;
      s_nxt.snd_pend  = 1'b1;
      s_nxt.snd_data  = s_r.xoff1;
    end else if (s_r.xoff_sent && rx_fifo_count <= lo_lvl) begin
      s_nxt.xoff_sent = 1'b0;
      s_nxt.snd_pend  = 1'b1;
      s_nxt.snd_data  = s_r.xon1;
    end

    // transmit-empty source: pending from reset and on every empty edge
    s_nxt.thr_d = thr_empty;
    if (thr_write || (isr_rd && interrupt_status_reg == UFC_ISR_THR))
      s_nxt.thri = 1'b0;
    if (thr_empty && !s_r.thr_d)
      s_nxt.thri = 1'b1;

    // permit input rising edge flag
    s_nxt.cts_d = permit_sel;
    if (isr_rd && interrupt_status_reg == UFC_ISR_CTS)
      s_nxt.ctsf = 1'b0;
    if (permit_sel && !s_r.cts_d && s_r.interrupt_enable_reg[UFC_IER_CTS])
      s_nxt.ctsf = 1'b1;

    // receive timeout counter; an empty fifo never times out
    if (rx_char_valid || rhr_read || rx_fifo_count == 8'h00) begin
      s_nxt.tcnt = 8'h00;
      s_nxt.tout = 1'b0;
    end else if (baud_tick && !s_r.tout) begin
      s_nxt.tcnt = s_r.tcnt + 8'h01;
      if (s_r.tcnt + 8'h01 >= tout_lim)
        s_nxt.tout = 1'b1;
    end

    s_nxt.irq = interrupt_status_reg != UFC_ISR_NONE;
  end

  // the whole state in one register bank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r       <= '0;
      s_r.thri  <= UFC_RST_THRI;
      s_r.thr_d <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs
  assign prdata             = s_r.prdata;
  assign rx_fifo_push       = s_r.push;
  assign rx_fifo_data       = s_r.push_data;
  assign tx_hold            = s_r.sw_halt || cts_halt;
  assign flow_char_req      = s_r.snd_pend;
  assign flow_char_data     = s_r.snd_data;
  assign flow_request_out   = !s_r.afc1[UFC_AFC1_REMAP] && s_r.rts_off;
  assign terminal_ready_out = s_r.afc1[UFC_AFC1_REMAP] && s_r.rts_off;
  assign irq_out            = s_r.irq;

endmodule
`default_nettype wire

//--- rtl/ufc_pkg.sv
/*
  Constants, register map and state type for the UART flow-control and
  receive-interrupt block.
  Assumes an APB master with 32-bit data and byte addresses on paddr.
*/
package ufc_pkg;

  // register byte addresses
  localparam logic [7:0] UFC_ADDR_IER   = 8'h00;
  localparam logic [7:0] UFC_ADDR_FCR   = 8'h04;
  localparam logic [7:0] UFC_ADDR_LCR   = 8'h08;
  localparam logic [7:0] UFC_ADDR_EFR   = 8'h0C;
  localparam logic [7:0] UFC_ADDR_XON1  = 8'h10;
  localparam logic [7:0] UFC_ADDR_XON2  = 8'h14;
  localparam logic [7:0] UFC_ADDR_XOFF1 = 8'h18;
  localparam logic [7:0] UFC_ADDR_XOFF2 = 8'h1C;
  localparam logic [7:0] UFC_ADDR_TXLVL = 8'h20;
  localparam logic [7:0] UFC_ADDR_RXLVL = 8'h24;
  localparam logic [7:0] UFC_ADDR_FLWH  = 8'h28;
  localparam logic [7:0] UFC_ADDR_FLWL  = 8'h2C;
  localparam logic [7:0] UFC_ADDR_AFC1  = 8'h30;
  localparam logic [7:0] UFC_ADDR_ISR   = 8'h34;
  localparam logic [7:0] UFC_ADDR_STAT  = 8'h38;

  // field positions
  localparam int UFC_EFR_RXSW   = 1; // compare received flow chars
  localparam int UFC_EFR_RXDBL  = 0; // two-character receive compare
  localparam int UFC_EFR_TXSW   = 3; // send flow chars
  localparam int UFC_EFR_TXDBL  = 2; // send two-character flow chars
  localparam int UFC_EFR_SPEC   = 5;
  localparam int UFC_EFR_AUTOR  = 6;
  localparam int UFC_EFR_AUTOC  = 7;
  localparam int UFC_IER_RX     = 0;
  localparam int UFC_IER_THR    = 1;
  localparam int UFC_IER_XOFF   = 5;
  localparam int UFC_IER_CTS    = 7;
  localparam int UFC_LCR_STOP   = 2;
  localparam int UFC_LCR_PAR    = 3;
  localparam int UFC_AFC1_REMAP = 2;

  // reset values
  localparam logic [7:0] UFC_RST_REG  = 8'h00;
  localparam logic       UFC_RST_THRI = 1'b1;

  // interrupt status codes
  localparam logic [7:0] UFC_ISR_NONE = 8'h01;
  localparam logic [7:0] UFC_ISR_THR  = 8'h02;
  localparam logic [7:0] UFC_ISR_RX   = 8'h04;
  localparam logic [7:0] UFC_ISR_TOUT = 8'h0C;
  localparam logic [7:0] UFC_ISR_XOFF = 8'h10;
  localparam logic [7:0] UFC_ISR_CTS  = 8'h20;

  // 32-entry levels selected by fifo control 7:6
  localparam logic [7:0] UFC_LEG_RX [4] = '{8'h08, 8'h10, 8'h18, 8'h1C};
  localparam logic [7:0] UFC_LEG_HI [4] = '{8'h08, 8'h10, 8'h18, 8'h1C};
  localparam logic [7:0] UFC_LEG_LO [4] = '{8'h00, 8'h07, 8'h0F, 8'h17};

  // character timing, in receive bit periods
  localparam logic [3:0] UFC_START_BITS = 4'h1;
  localparam logic [3:0] UFC_MIN_WORD   = 4'h5;
  localparam logic [2:0] UFC_TOUT_CHARS = 3'h4;

  typedef struct packed {
    logic [7:0]  interrupt_enable_reg;
    logic [7:0]  fifo_control_reg;
    logic [7:0]  line_control_reg;
    logic [7:0]  enhanced_feature_reg;
    logic [7:0]  xon1;
    logic [7:0]  xon2;
    logic [7:0]  xoff1;
    logic [7:0]  xoff2;
    logic [7:0]  txlvl;
    logic [7:0]  rxlvl;
    logic [7:0]  flwh;
    logic [7:0]  flwl;
    logic [7:0]  afc1;
    logic [31:0] prdata;
    logic        rts_off;
    logic        sw_halt;
    logic        xoff_sent;
    logic        snd_pend;
    logic        snd_idx;
    logic [7:0]  snd_data;
    logic        prev_on;
    logic        prev_off;
    logic        sflag;
    logic        thri;
    logic        thr_d;
    logic        ctsf;
    logic        cts_d;
    logic [7:0]  tcnt;
    logic        tout;
    logic        push;
    logic [7:0]  push_data;
    logic        irq;
  } ufc_state_t;

endpackage
